/* File: inc/timer8_pkg.sv */
// Package with register map, field layout and mode encodings of the 8-bit waveform timer.
package timer8_pkg;

  localparam logic [2:0] ADDR_CONTROL     = 3'h0;
  localparam logic [2:0] ADDR_COUNTER     = 3'h1;
  localparam logic [2:0] ADDR_COMPARE     = 3'h2;
  localparam logic [2:0] ADDR_FLAGS       = 3'h3;
  localparam logic [2:0] ADDR_PIN_CTRL    = 3'h4;

  localparam int CTL_FORCE_BIT    = 7;
  localparam int CTL_MODE_LOW_BIT = 6;
  localparam int CTL_ACTION_HI    = 5;
  localparam int CTL_ACTION_LO    = 4;
  localparam int CTL_MODE_HI_BIT  = 3;
  localparam int CTL_CLKSEL_HI    = 2;
  localparam int CTL_CLKSEL_LO    = 0;

  localparam int FLAG_OVERFLOW_BIT = 0;
  localparam int FLAG_COMPARE_BIT  = 1;
  localparam int PIN_DIR_BIT       = 0;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX     = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM  = 8'h00;

  localparam int PWM_PHASE_PERIOD = 510;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_PHASE  = 2'h1,
    MODE_CLEAR  = 2'h2,
    MODE_FAST   = 2'h3
  } wave_mode_t;

  typedef enum logic [2:0] {
    CLK_STOP   = 3'h0,
    CLK_DIV1   = 3'h1,
    CLK_DIV8   = 3'h2,
    CLK_DIV64  = 3'h3,
    CLK_DIV256 = 3'h4,
    CLK_DIV1K  = 3'h5,
    CLK_EXT_FALL = 3'h6,
    CLK_EXT_RISE = 3'h7
  } clock_sel_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic tap8;
    logic tap64;
    logic tap256;
    logic tap1024;
  } prescale_taps_t;

endpackage

/* File: rtl/timer8_waveform_unit.sv */
// 8-bit timer/counter with one compare channel and a waveform output pin.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module timer8_waveform_unit (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_reset_n,
  input  wire logic [2:0]                    i_reg_addr,
  input  wire logic [7:0]                    i_reg_wdata,
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  output logic      [7:0]                    o_reg_rdata,
  input  wire timer8_pkg::prescale_taps_t    i_prescale_taps,
  input  wire logic                          i_external_count_pin,
  input  wire logic                          i_port_data,
  input  wire logic                          i_overflow_ack,
  input  wire logic                          i_compare_ack,
  output logic                               o_pin_out,
  output logic                               o_pin_oe,
  output logic                               o_waveform_output,
  output logic                               o_overflow_flag,
  output logic                               o_compare_flag
);

  timer8_pkg::reg_req_t req;
  logic [7:0] control_q;
  logic [7:0] counter_value_q;
  logic [7:0] compare_value_q;
  logic [7:0] compare_buf_q;
  logic       count_down_q;
  logic       block_match_q;
  logic       ext_pin_q;
  logic       pin_dir_q;
  logic       waveform_output_q;
  logic       overflow_flag_q;
  logic       compare_flag_q;
  logic [7:0] rdata_q;

  timer8_pkg::wave_mode_t mode;
  timer8_pkg::clock_sel_t clk_sel;
  logic [1:0] action;
  logic       timer_tick;
  logic       is_pwm;
  logic       counter_wr;
  logic       match;
  logic       force_strobe;
  logic       at_top;
  logic       ext_rise;
  logic       ext_fall;

  assign req = '{addr: i_reg_addr, wdata: i_reg_wdata, wr: i_reg_wr, rd: i_reg_rd};

  // Mode field straddles the action field: bit 3 sits below it and bit 6 above it.
  assign mode    = timer8_pkg::wave_mode_t'({control_q[timer8_pkg::CTL_MODE_HI_BIT],
                                             control_q[timer8_pkg::CTL_MODE_LOW_BIT]});
  assign clk_sel = timer8_pkg::clock_sel_t'(control_q[timer8_pkg::CTL_CLKSEL_HI:
                                                      timer8_pkg::CTL_CLKSEL_LO]);
  assign action  = control_q[timer8_pkg::CTL_ACTION_HI:timer8_pkg::CTL_ACTION_LO];
  assign is_pwm  = (mode == timer8_pkg::MODE_PHASE) || (mode == timer8_pkg::MODE_FAST);

  // The pin is taken as synchronous; one register gives the previous level for edge finding.
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      ext_pin_q <= 1'b0;
    end else begin
      ext_pin_q <= i_external_count_pin;
    end
  end

  assign ext_rise = i_external_count_pin & ~ext_pin_q;
  assign ext_fall = ~i_external_count_pin & ext_pin_q;

  // The taps are one-cycle pulses of the shared divider.
  always_comb begin
    case (clk_sel)
      timer8_pkg::CLK_STOP:     timer_tick = 1'b0;
      timer8_pkg::CLK_DIV1:     timer_tick = 1'b1;
      timer8_pkg::CLK_DIV8:     timer_tick = i_prescale_taps.tap8;
      timer8_pkg::CLK_DIV64:    timer_tick = i_prescale_taps.tap64;
      timer8_pkg::CLK_DIV256:   timer_tick = i_prescale_taps.tap256;
      timer8_pkg::CLK_DIV1K:    timer_tick = i_prescale_taps.tap1024;
      timer8_pkg::CLK_EXT_FALL: timer_tick = ext_fall;
      timer8_pkg::CLK_EXT_RISE: timer_tick = ext_rise;
      default:                  timer_tick = 1'b0;
    endcase
  end

  assign counter_wr   = req.wr && (req.addr == timer8_pkg::ADDR_COUNTER);
  assign match        = timer_tick && !block_match_q &&
                        (counter_value_q == compare_value_q);
  assign force_strobe = req.wr && (req.addr == timer8_pkg::ADDR_CONTROL) &&
                        req.wdata[timer8_pkg::CTL_FORCE_BIT] && !is_pwm;
  assign at_top       = counter_value_q == timer8_pkg::COUNT_MAX;

  // Control register; the force bit is a strobe and is never stored.
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      control_q <= timer8_pkg::CONTROL_RESET;
      pin_dir_q <= 1'b0;
    end else begin
      if (req.wr && req.addr == timer8_pkg::ADDR_CONTROL) begin
        control_q <= {1'b0, req.wdata[6:0]};
      end
      if (req.wr && req.addr == timer8_pkg::ADDR_PIN_CTRL) begin
        pin_dir_q <= req.wdata[timer8_pkg::PIN_DIR_BIT];
      end
    end
  end

  // Compare buffer: written freely, copied to the active value per mode.
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      compare_buf_q   <= timer8_pkg::COMPARE_RESET;
      compare_value_q <= timer8_pkg::COMPARE_RESET;
    end else begin
      if (req.wr && req.addr == timer8_pkg::ADDR_COMPARE) begin
        compare_buf_q <= req.wdata;
      end
      if (!is_pwm) begin
        compare_value_q <= (req.wr && req.addr == timer8_pkg::ADDR_COMPARE) ?
                           req.wdata : compare_buf_q;
      end else if (timer_tick && mode == timer8_pkg::MODE_PHASE && at_top) begin
        compare_value_q <= compare_buf_q;
      end else if (timer_tick && mode == timer8_pkg::MODE_FAST && at_top) begin
        compare_value_q <= compare_buf_q;
      end
    end
  end

  // Counter and direction.
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      counter_value_q <= timer8_pkg::COUNTER_RESET;
      count_down_q    <= 1'b0;
      block_match_q   <= 1'b0;
    end else begin
      if (counter_wr) begin
        counter_value_q <= req.wdata;
        block_match_q   <= 1'b1;
      end else if (timer_tick) begin
        block_match_q <= 1'b0;
        case (mode)
          timer8_pkg::MODE_PHASE: begin
            if (at_top) begin
              count_down_q    <= 1'b1;
              counter_value_q <= counter_value_q - 8'h01;
            end else if (count_down_q && counter_value_q == timer8_pkg::COUNT_BOTTOM) begin
              count_down_q    <= 1'b0;
              counter_value_q <= counter_value_q + 8'h01;
            end else if (count_down_q) begin
              counter_value_q <= counter_value_q - 8'h01;
            end else begin
              counter_value_q <= counter_value_q + 8'h01;
            end
          end
          timer8_pkg::MODE_CLEAR: begin
            counter_value_q <= (counter_value_q == compare_value_q) ?
                               timer8_pkg::COUNT_BOTTOM : counter_value_q + 8'h01;
            count_down_q    <= 1'b0;
          end
          default: begin
            counter_value_q <= counter_value_q + 8'h01;
            count_down_q    <= 1'b0;
          end
        endcase
      end
    end
  end

  // Waveform register.
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      waveform_output_q <= 1'b0;
    end else if (force_strobe) begin
      case (action)
        2'h1:    waveform_output_q <= ~waveform_output_q;
        2'h2:    waveform_output_q <= 1'b0;
        2'h3:    waveform_output_q <= 1'b1;
        default: waveform_output_q <= waveform_output_q;
      endcase
    end else if (timer_tick && !block_match_q) begin
      case (mode)
        timer8_pkg::MODE_NORMAL, timer8_pkg::MODE_CLEAR: begin
          if (match) begin
            case (action)
              2'h1:    waveform_output_q <= ~waveform_output_q;
              2'h2:    waveform_output_q <= 1'b0;
              2'h3:    waveform_output_q <= 1'b1;
              default: waveform_output_q <= waveform_output_q;
            endcase
          end
        end
        timer8_pkg::MODE_FAST: begin
          if (action[1]) begin
            if (compare_value_q == timer8_pkg::COUNT_MAX) begin
              if (at_top) begin
                waveform_output_q <= ~action[0];
              end
            end else if (at_top) begin
              waveform_output_q <= ~action[0];
            end else if (match) begin
              waveform_output_q <= action[0];
            end
          end
        end
        timer8_pkg::MODE_PHASE: begin
          if (action[1]) begin
            if (at_top) begin
              // Peak takes the up-count match state of the value loaded here.
              waveform_output_q <= (compare_buf_q == timer8_pkg::COUNT_MAX) ?
                                   ~action[0] : action[0];
            end else if (counter_value_q == timer8_pkg::COUNT_BOTTOM && count_down_q) begin
              if (compare_value_q == timer8_pkg::COUNT_BOTTOM) begin
                waveform_output_q <= action[0];
              end
            end else if (match) begin
              waveform_output_q <= count_down_q ? ~action[0] : action[0];
            end
          end
        end
        default: waveform_output_q <= waveform_output_q;
      endcase
    end
  end

  // Flags: hardware set wins over a clear in the same cycle.
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      overflow_flag_q <= 1'b0;
      compare_flag_q  <= 1'b0;
    end else begin
      if (timer_tick && !counter_wr &&
          ((mode == timer8_pkg::MODE_PHASE) ?
           (count_down_q && counter_value_q == timer8_pkg::COUNT_BOTTOM) : at_top)) begin
        overflow_flag_q <= 1'b1;
      end else if (i_overflow_ack || (req.wr && req.addr == timer8_pkg::ADDR_FLAGS &&
                                      req.wdata[timer8_pkg::FLAG_OVERFLOW_BIT])) begin
        overflow_flag_q <= 1'b0;
      end
      if (match) begin
        compare_flag_q <= 1'b1;
      end else if (i_compare_ack || (req.wr && req.addr == timer8_pkg::ADDR_FLAGS &&
                                     req.wdata[timer8_pkg::FLAG_COMPARE_BIT])) begin
        compare_flag_q <= 1'b0;
      end
    end
  end

  // Read data, one cycle after the strobe.
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        timer8_pkg::ADDR_CONTROL:  rdata_q <= control_q;
        timer8_pkg::ADDR_COUNTER:  rdata_q <= counter_value_q;
        timer8_pkg::ADDR_COMPARE:  rdata_q <= compare_buf_q;
        timer8_pkg::ADDR_FLAGS:    rdata_q <= {6'h00, compare_flag_q, overflow_flag_q};
        timer8_pkg::ADDR_PIN_CTRL: rdata_q <= {7'h00, pin_dir_q};
        default:                   rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign o_reg_rdata       = rdata_q;
  assign o_waveform_output = waveform_output_q;
  assign o_overflow_flag   = overflow_flag_q;
  assign o_compare_flag    = compare_flag_q;
  assign o_pin_out         = (action != 2'h0) ? waveform_output_q : i_port_data;
  assign o_pin_oe          = pin_dir_q;

endmodule

/* File: verif/prescaler_model.sv */
// Shared free-running prescaler model that feeds one-cycle tap pulses to the timer.
`timescale 1ns/100ps
module prescaler_model (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset_n,
  output timer8_pkg::prescale_taps_t o_taps
);
  logic [9:0] div_q;

  // The divider ignores the timer's clock select, so a prescaled start may lag a period.
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_q + 10'h001;
    end
  end

  assign o_taps.tap8    = &div_q[2:0];
  assign o_taps.tap64   = &div_q[5:0];
  assign o_taps.tap256  = &div_q[7:0];
  assign o_taps.tap1024 = &div_q;
endmodule

/* File: verif/tb_top.sv */
// Self-checking testbench for the 8-bit waveform timer.
`timescale 1ns/100ps
module tb_top;
  logic                       i_ref_clk = 1'b0;
  logic                       i_reset_n = 1'b0;
  logic [2:0]                 i_reg_addr = 3'h0;
  logic [7:0]                 i_reg_wdata = 8'h00;
  logic                       i_reg_wr = 1'b0;
  logic                       i_reg_rd = 1'b0;
  logic [7:0]                 o_reg_rdata;
  timer8_pkg::prescale_taps_t i_prescale_taps;
  logic                       i_external_count_pin = 1'b0;
  logic                       i_port_data = 1'b0;
  logic                       i_overflow_ack = 1'b0;
  logic                       i_compare_ack = 1'b0;
  logic                       o_pin_out;
  logic                       o_pin_oe;
  logic                       o_waveform_output;
  logic                       o_overflow_flag;
  logic                       o_compare_flag;
  int                         err_total = 0;
  int                         num_checks = 0;
  int                         n;
  int                         divs [6] = '{0, 1, 8, 64, 256, 1024};
  logic [1:0]                 acts [4] = '{2'h3, 2'h1, 2'h2, 2'h1};
  logic [1:0]                 pm [3] = '{2'h1, 2'h3, 2'h1};
  logic [2:0]                 pc [3] = '{3'h1, 3'h1, 3'h2};
  logic [31:0]                seed = 32'h887d_972f;
  logic [31:0]                r;
  logic [7:0]                 c;
  logic [7:0]                 rd_v;
  logic                       e;

  always #10 i_ref_clk = ~i_ref_clk;

  timer8_waveform_unit dut_u (.*);
  prescaler_model pre_u (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .o_taps(i_prescale_taps));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Force bit always zero here, so PWM-mode writes never strobe it.
  function automatic logic [7:0] ctl(input logic [1:0] m, input logic [1:0] a,
                                     input logic [2:0] s);
    return {1'b0, m[0], a, m[1], s};
  endfunction

  function automatic int exp_period(input logic [1:0] m, input logic [2:0] s);
    return (m == timer8_pkg::MODE_PHASE ? timer8_pkg::PWM_PHASE_PERIOD : 256) * divs[s];
  endfunction

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1 rd_v = o_reg_rdata;
  endtask

  task automatic wait_hi(input int s, input int lim);
    n = 0;
    while ((s ? o_overflow_flag : o_compare_flag) !== 1'b1) begin
      @(posedge i_ref_clk);
      #1 n++;
      if (n > lim) begin
        err_total++;
        finish_test();
      end
    end
  endtask

  task automatic toggle(input int k);
    repeat (k) begin
      @(posedge i_ref_clk);
      i_external_count_pin <= !i_external_count_pin;
      repeat (3) @(posedge i_ref_clk);
    end
  endtask

  task automatic next_rise(output int t);
    logic p;
    t = 0;
    do begin
      p = o_waveform_output;
      @(posedge i_ref_clk);
      #1 t++;
    end while (!(p === 1'b0 && o_waveform_output === 1'b1) && t < 9000);
    if (t >= 9000) begin
      err_total++;
      finish_test();
    end
  endtask

  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      rd(3'(a));
      chk(rd_v, 8'h00);
    end
    wr(timer8_pkg::ADDR_PIN_CTRL, 8'h01);
    r = rnd();
    i_port_data <= r[0];
    @(posedge i_ref_clk);
    #1 chk(o_pin_out, r[0]);
    chk(o_pin_oe, 1'b1);
    e = 1'b0;
    foreach (acts[i]) begin
      wr(timer8_pkg::ADDR_CONTROL, ctl(2'h0, acts[i], 3'h0));
      wr(timer8_pkg::ADDR_CONTROL, ctl(2'h0, acts[i], 3'h0) | 8'h80);
      e = acts[i][1] ? acts[i][0] : !e;
      #1 chk(o_waveform_output, e);
      chk(o_compare_flag, 1'b0);
      rd(timer8_pkg::ADDR_CONTROL);
      chk(rd_v, ctl(2'h0, acts[i], 3'h0));
    end
    r = rnd();
    c = 8'h08 + {1'b0, r[6:0]};
    wr(timer8_pkg::ADDR_FLAGS, 8'h03);
    wr(timer8_pkg::ADDR_COMPARE, c);
    wr(timer8_pkg::ADDR_COUNTER, c - 8'h04);
    wr(timer8_pkg::ADDR_CONTROL, ctl(2'h0, 2'h1, 3'h1));
    wait_hi(0, 20);
    chk(o_compare_flag, 1'b1);
    wait_hi(1, 300);
    wr(timer8_pkg::ADDR_CONTROL, ctl(2'h0, 2'h1, 3'h0));
    e = !e;
    #1 chk(o_overflow_flag, 1'b1);
    chk(o_waveform_output, e);
    repeat (2) @(posedge i_ref_clk);
    i_compare_ack <= 1'b1;
    @(posedge i_ref_clk);
    i_compare_ack <= 1'b0;
    wr(timer8_pkg::ADDR_FLAGS, 8'h01);
    #1 chk({o_compare_flag, o_overflow_flag}, 2'b00);
    wr(timer8_pkg::ADDR_COMPARE, 8'h05);
    wr(timer8_pkg::ADDR_CONTROL, ctl(2'h0, 2'h1, 3'h7));
    wr(timer8_pkg::ADDR_COUNTER, 8'h05);
    toggle(1);
    #1 chk(o_compare_flag, 1'b0);
    rd(timer8_pkg::ADDR_COUNTER);
    chk(rd_v, 8'h06);
    wr(timer8_pkg::ADDR_CONTROL, ctl(2'h0, 2'h1, 3'h6));
    wr(timer8_pkg::ADDR_COUNTER, 8'h00);
    toggle(5);
    rd(timer8_pkg::ADDR_COUNTER);
    chk(rd_v, 8'h03);
    r = rnd();
    c = 8'h04 + {4'h0, r[3:0]};
    wr(timer8_pkg::ADDR_COMPARE, c);
    wr(timer8_pkg::ADDR_CONTROL, ctl(2'h2, 2'h0, 3'h1));
    repeat (20) begin
      rd(timer8_pkg::ADDR_COUNTER);
      chk(rd_v <= c, 1'b1);
    end
    foreach (pm[i]) begin
      r = rnd();
      wr(timer8_pkg::ADDR_COMPARE, 8'h01 + {1'b0, r[6:0]});
      wr(timer8_pkg::ADDR_CONTROL, ctl(pm[i], 2'h2, pc[i]));
      repeat (3) next_rise(n);
      chk(n, exp_period(pm[i], pc[i]));
    end
    for (int k = 0; k < 4; k++) begin
      wr(timer8_pkg::ADDR_COMPARE, k[0] ? 8'hff : 8'h00);
      wr(timer8_pkg::ADDR_CONTROL, ctl(2'h1, {1'b1, k[1]}, 3'h1));
      repeat (1100) @(posedge i_ref_clk);
      repeat (520) begin
        @(posedge i_ref_clk);
        #1 chk(o_waveform_output, k[0] ^ k[1]);
      end
    end
    // Phase correct mode has passed bottom many times, so the overflow flag must be up.
    wr(timer8_pkg::ADDR_CONTROL, ctl(2'h1, 2'h2, 3'h0));
    #1 chk(o_overflow_flag, 1'b1);
    i_overflow_ack <= 1'b1;
    @(posedge i_ref_clk);
    i_overflow_ack <= 1'b0;
    @(posedge i_ref_clk);
    #1 chk(o_overflow_flag, 1'b0);
    finish_test();
  end
endmodule

/* File: verif/timer8_waveform_unit_properties.sv */
// Port-level checker for the 8-bit waveform timer, bound to its top module.
`timescale 1ns/100ps
module timer8_checker (
  input wire logic       i_ref_clk,
  input wire logic       i_reset_n,
  input wire logic [2:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       i_port_data,
  input wire logic       i_compare_ack,
  input wire logic       o_pin_out,
  input wire logic       o_pin_oe,
  input wire logic       o_waveform_output,
  input wire logic       o_overflow_flag,
  input wire logic       o_compare_flag
);
  logic [7:0] ctl_q;
  logic       stop_q;
  logic       ctl_wr;
  logic       stopped;
  logic       force_same;
  logic       force_exp;

  assign ctl_wr = i_reg_wr && i_reg_addr == timer8_pkg::ADDR_CONTROL;
  // Stopped for two edges, so no tick can still be in flight.
  assign stopped = stop_q && ctl_q[2:0] == 3'h0;
  assign force_same = ctl_wr && i_reg_wdata[7] && !i_reg_wdata[6] && !ctl_q[6] && stopped
                      && i_reg_wdata[5:0] == ctl_q[5:0] && ctl_q[5:4] != 2'h0;
  assign force_exp = ctl_q[5] ? ctl_q[4] : !o_waveform_output;

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      ctl_q <= timer8_pkg::CONTROL_RESET;
    end else if (ctl_wr) begin
      ctl_q <= {1'b0, i_reg_wdata[6:0]};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    stop_q <= !i_reset_n || ctl_q[2:0] == 3'h0;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  property p_force_rd0;
    i_reg_rd && i_reg_addr == timer8_pkg::ADDR_CONTROL |=> !o_reg_rdata[7];
  endproperty
  a_force_rd0: assert property (p_force_rd0) else $error("force bit read as one");
  property p_pin_port; ctl_q[5:4] == 2'h0 |-> o_pin_out == i_port_data; endproperty
  a_pin_port: assert property (p_pin_port) else $error("pin not port data");
  property p_pin_wave; ctl_q[5:4] != 2'h0 |-> o_pin_out == o_waveform_output; endproperty
  a_pin_wave: assert property (p_pin_wave) else $error("pin not waveform");
  property p_pin_oe;
    i_reg_wr && i_reg_addr == timer8_pkg::ADDR_PIN_CTRL |=> o_pin_oe == $past(i_reg_wdata[0]);
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("pin enable wrong");
  property p_stop_cmp; stopped && !o_compare_flag |=> !o_compare_flag; endproperty
  a_stop_cmp: assert property (p_stop_cmp) else $error("match while stopped");
  property p_force; force_same |=> o_waveform_output == $past(force_exp); endproperty
  a_force: assert property (p_force) else $error("forced action wrong");
  property p_cmp_ack; i_compare_ack && stopped |=> !o_compare_flag; endproperty
  a_cmp_ack: assert property (p_cmp_ack) else $error("compare flag not cleared");
  property p_ovf_clr;
    i_reg_wr && i_reg_addr == timer8_pkg::ADDR_FLAGS && i_reg_wdata[0] && stopped
      |=> !o_overflow_flag;
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow flag not cleared");
  property p_wave_hold; stopped && !ctl_wr |=> $stable(o_waveform_output); endproperty
  a_wave_hold: assert property (p_wave_hold) else $error("waveform moved while stopped");
endmodule

bind timer8_waveform_unit timer8_checker chk_u (.*);
